// [hdl/prot_regs.svh]
// Purpose: named constants for protection and trace provisioning
// Assumes: 40 MHz system clock
// Notes: times kept in their own units, cycle counts derived
`ifndef PROT_REGS_SVH
`define PROT_REGS_SVH
`define CLK_HZ 40000000
`define WTR_MAX_MIN 4'hC
`define WTR_RESET_MIN 4'h5
`define HOLDOFF_STEP_MS 100
`define HOLDOFF_MAX_STEPS 7'h64
`define HOLDOFF_RESET_STEPS 7'h00
`define SECONDS_PER_MIN 60
`define TRACE_LEN 16
`define TRACE_IDX_W 4
`define LAST_TRACE_IDX 4'hF
`endif

// [hdl/prot_pkg.sv]
// Purpose: types for protection and trace provisioning
// Assumes: nothing beyond the constants header
// Notes: command codes are shared by all protection kinds
package prot_pkg;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_CLEAR, CMD_LOCKOUT, CMD_FORCED, CMD_MANUAL,
        CMD_EXERCISE, CMD_LOCKOUT_NORMAL, CMD_CLEAR_LOCKOUT_NORMAL,
        CMD_LP_SPAN, CMD_FS_RING, CMD_FS_SPAN, CMD_MS_RING, CMD_MS_SPAN,
        CMD_EX_RING, CMD_EX_SPAN, CMD_LP_ALL
    } ext_cmd_t;
    typedef enum logic [1:0] {
        SCHEME_MSP, SCHEME_RING, SCHEME_SNC, SCHEME_TRAIL
    } scheme_t;
    typedef struct packed {
        logic revert_select;
        logic snc_monitor_type;
        logic monitor_type_set;
        logic direction_select;
        logic extra_traffic_flag;
        logic [3:0] restore_wait_minutes;
        logic [6:0] holdoff_interval;
    } prot_cfg_t;
    typedef struct packed {
        logic expected_trace_format;
        logic single_byte_mode;
        logic trace_mismatch_disable;
    } trace_cfg_t;
endpackage

// [hdl/prot_trace_prov.sv]
// Operation
// - operation type settable revertive or not; resets to non-revertive.
// - protection type inherent or non-intrusive; operational only once written.
// - wait-to-restore in whole minutes 0..12, reset 5.
// - hold-off in 100 ms steps 0..10 s, reset 0.
// - settings may change while protection runs; applied at once.
// - when switching is active, protection replaces working facility.
// - manual switch held until released.
// - forced switch and lockout held until released.
// - MS adds lockout of normal and its clear to the five basic commands.
// - ring accepts ring and span variants plus lockout of all spans.
// - SNC and trail accept only clear, lockout, forced, manual, exercise.
// - each performed switch reported as a one-cycle valueless event.
// - sent and expected trace and format accepted; format defaults mode 1.
// - trace mismatch detection can be disabled.
// - expected trace may be a single repeating byte.
// - accepted trace returned on request.
// - active client chosen by per-adapter activation, inactive at reset.
// - single-client access point has fixed, non-writable activation.
// - accepted payload label returned on request.
// - linear MS holds direction and extra-traffic settings.
//
// Purpose: protection provisioning, external command and trace reporting
// Assumes: manager inputs come from logic on I_CLK
// Notes: the switching algorithm itself lives outside; this keeps
//        request state, timers and the failure-driven selection
`timescale 1ns/100ps
`include "prot_regs.svh"

module prot_trace_prov
    import prot_pkg::*;
#(
    parameter int N_ADAPT = 2,
    parameter bit SINGLE_CLIENT = 1'b0,
    parameter logic [31:0] SEC_CYCLES = `CLK_HZ,
    parameter logic [31:0] STEP_CYCLES = `CLK_HZ / 1000 * `HOLDOFF_STEP_MS
)
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire scheme_t i_scheme,
    input wire logic i_cfg_wr,
    input wire prot_cfg_t i_cfg,
    input wire logic i_cmd_valid,
    input wire ext_cmd_t i_external_switch_command,
    input wire logic i_working_fail,
    input wire logic i_protect_fail,
    input wire logic i_trace_wr,
    input wire trace_cfg_t i_trace_cfg,
    input wire logic [7:0] i_sent_trace_value,
    input wire logic [7:0] i_expected_trace_value,
    input wire logic i_rx_trace_valid,
    input wire logic [7:0] i_rx_trace_byte,
    input wire logic i_trace_req,
    input wire logic i_label_req,
    input wire logic [7:0] i_rx_label,
    input wire logic i_act_wr,
    input wire logic [N_ADAPT-1:0] i_adapter_activate,
    output logic [7:0] o_tx_trace_byte,
    output logic o_switch_select,
    output logic o_switch_event_report,
    output logic o_prot_operational,
    output ext_cmd_t o_active_command,
    output prot_cfg_t o_cfg,
    output logic o_trace_mismatch_defect,
    output logic o_trace_ack,
    output logic [7:0] o_accepted_trace_value,
    output logic o_label_ack,
    output logic [7:0] o_accepted_payload_label,
    output logic [N_ADAPT-1:0] o_adapter_activate
);

    initial
    begin
        if (N_ADAPT < 1 || SEC_CYCLES < 1 || STEP_CYCLES < 1)
            $error("prot_trace_prov: bad parameter");
        if (SINGLE_CLIENT && N_ADAPT != 1)
            $error("prot_trace_prov: single client needs one adapter");
    end

    ////////////////////////////////////////////////////////////////////
    // command legality per scheme

    function automatic logic cmd_allowed(scheme_t s, ext_cmd_t c);
        logic ok;
        ok = 1'b0;
        case (s)
            SCHEME_MSP:
                ok = (c >= CMD_CLEAR &&
                      c <= CMD_CLEAR_LOCKOUT_NORMAL);
            SCHEME_RING:
                ok = (c == CMD_CLEAR || c >= CMD_LP_SPAN ||
                      c == CMD_LOCKOUT_NORMAL);
            default:
                ok = (c >= CMD_CLEAR && c <= CMD_EXERCISE);
        endcase
        return ok;
    endfunction

    function automatic logic is_lockout(ext_cmd_t c);
        return c == CMD_LOCKOUT || c == CMD_LP_SPAN || c == CMD_LP_ALL;
    endfunction

    function automatic logic is_forced(ext_cmd_t c);
        return c == CMD_FORCED || c == CMD_FS_RING || c == CMD_FS_SPAN;
    endfunction

    function automatic logic is_manual(ext_cmd_t c);
        return c == CMD_MANUAL || c == CMD_MS_RING || c == CMD_MS_SPAN;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // provisioning

    prot_cfg_t cfg_q;
    prot_cfg_t cfg_d;

    always_comb
    begin
        cfg_d = i_cfg;
        if (i_cfg.restore_wait_minutes > `WTR_MAX_MIN)
            cfg_d.restore_wait_minutes = cfg_q.restore_wait_minutes;
        if (i_cfg.holdoff_interval > `HOLDOFF_MAX_STEPS)
            cfg_d.holdoff_interval = cfg_q.holdoff_interval;
        cfg_d.monitor_type_set = 1'b1;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            cfg_q <= '0;
            cfg_q.restore_wait_minutes <= `WTR_RESET_MIN;
            cfg_q.holdoff_interval <= `HOLDOFF_RESET_STEPS;
        end
        else if (i_cfg_wr)
            cfg_q <= cfg_d;
    end

    assign o_cfg = cfg_q;
    // non-SNC schemes need no monitor type
    assign o_prot_operational =
        cfg_q.monitor_type_set || i_scheme != SCHEME_SNC;

    ////////////////////////////////////////////////////////////////////
    // external command state

    ext_cmd_t cmd_q;

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            cmd_q <= CMD_NONE;
        else if (i_cmd_valid && cmd_allowed(i_scheme,
                 i_external_switch_command))
        begin
            if (i_external_switch_command == CMD_CLEAR ||
                i_external_switch_command == CMD_CLEAR_LOCKOUT_NORMAL)
                cmd_q <= CMD_NONE;
            else
                cmd_q <= i_external_switch_command;
        end
    end

    assign o_active_command = cmd_q;

    ////////////////////////////////////////////////////////////////////
    // hold-off and wait-to-restore timers

    logic [31:0] step_cnt_q;
    logic [6:0] ho_cnt_q;
    logic ho_done;
    logic [31:0] sec_cnt_q;
    logic [9:0] wtr_sec_q;
    logic wtr_run_q;
    logic sel_q;

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST || !i_working_fail)
        begin
            step_cnt_q <= '0;
            ho_cnt_q <= '0;
        end
        else if (!ho_done)
        begin
            if (step_cnt_q == STEP_CYCLES - 32'h1)
            begin
                step_cnt_q <= '0;
                ho_cnt_q <= ho_cnt_q + 7'h1;
            end
            else
                step_cnt_q <= step_cnt_q + 32'h1;
        end
    end

    // live compare so a changed hold-off applies at once
    assign ho_done = i_working_fail &&
        ho_cnt_q >= cfg_q.holdoff_interval;

    logic [9:0] wtr_limit;
    assign wtr_limit = 10'(cfg_q.restore_wait_minutes * `SECONDS_PER_MIN);

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST || !wtr_run_q)
        begin
            sec_cnt_q <= '0;
            wtr_sec_q <= '0;
        end
        else if (sec_cnt_q == SEC_CYCLES - 32'h1)
        begin
            sec_cnt_q <= '0;
            wtr_sec_q <= wtr_sec_q + 10'h1;
        end
        else
            sec_cnt_q <= sec_cnt_q + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // selection: 0 working, 1 protection

    logic sel_d;
    logic wtr_run_d;

    always_comb
    begin
        sel_d = sel_q;
        wtr_run_d = 1'b0;
        if (is_lockout(cmd_q) || !o_prot_operational)
            sel_d = 1'b0;
        else if (is_forced(cmd_q))
            sel_d = 1'b1;
        else if (ho_done && !i_protect_fail)
            sel_d = 1'b1;
        else if (is_manual(cmd_q))
            sel_d = !i_protect_fail;
        else if (sel_q && cfg_q.revert_select && !i_working_fail)
        begin
            wtr_run_d = 1'b1;
            if (wtr_run_q && wtr_sec_q >= wtr_limit)
            begin
                sel_d = 1'b0;
                wtr_run_d = 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            sel_q <= 1'b0;
            wtr_run_q <= 1'b0;
            o_switch_event_report <= 1'b0;
        end
        else
        begin
            sel_q <= sel_d;
            wtr_run_q <= wtr_run_d;
            o_switch_event_report <= sel_d != sel_q;
        end
    end

    assign o_switch_select = sel_q;

    ////////////////////////////////////////////////////////////////////
    // trace identifier

    trace_cfg_t tcfg_q;
    logic [7:0] tx_mem [`TRACE_LEN];
    logic [7:0] ex_mem [`TRACE_LEN];
    logic [7:0] ac_mem [`TRACE_LEN];
    logic [`TRACE_IDX_W-1:0] wr_idx_q;
    logic [`TRACE_IDX_W-1:0] tx_idx_q;
    logic [`TRACE_IDX_W-1:0] rx_idx_q;
    logic [`TRACE_IDX_W-1:0] rd_idx_q;
    logic mism_q;
    logic frame_mism_q;

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            tcfg_q <= '0;
            wr_idx_q <= '0;
        end
        else if (i_trace_wr)
        begin
            tcfg_q <= i_trace_cfg;
            tx_mem[wr_idx_q] <= i_sent_trace_value;
            ex_mem[wr_idx_q] <= i_expected_trace_value;
            wr_idx_q <= wr_idx_q + 1'b1;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            tx_idx_q <= '0;
            o_tx_trace_byte <= 8'h00;
        end
        else
        begin
            tx_idx_q <= tx_idx_q + 1'b1;
            o_tx_trace_byte <= tx_mem[tx_idx_q];
        end
    end

    logic [7:0] exp_byte;
    // single-byte form compares every byte with entry 0
    assign exp_byte = tcfg_q.single_byte_mode ?
        ex_mem[0] : ex_mem[rx_idx_q];

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            rx_idx_q <= '0;
            frame_mism_q <= 1'b0;
            mism_q <= 1'b0;
        end
        else if (i_rx_trace_valid)
        begin
            ac_mem[rx_idx_q] <= i_rx_trace_byte;
            rx_idx_q <= rx_idx_q + 1'b1;
            if (rx_idx_q == `LAST_TRACE_IDX)
            begin
                mism_q <= frame_mism_q || i_rx_trace_byte != exp_byte;
                frame_mism_q <= 1'b0;
            end
            else
                frame_mism_q <= frame_mism_q ||
                    i_rx_trace_byte != exp_byte;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            o_trace_mismatch_defect <= 1'b0;
        else
            o_trace_mismatch_defect <=
                mism_q && !tcfg_q.trace_mismatch_disable;
    end

    // each request cycle returns the next accepted trace byte, one cycle later
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            rd_idx_q <= '0;
            o_trace_ack <= 1'b0;
            o_accepted_trace_value <= 8'h00;
        end
        else
        begin
            o_trace_ack <= i_trace_req;
            if (i_trace_req)
            begin
                o_accepted_trace_value <= ac_mem[rd_idx_q];
                rd_idx_q <= rd_idx_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // payload label and activation

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            o_label_ack <= 1'b0;
            o_accepted_payload_label <= 8'h00;
        end
        else
        begin
            o_label_ack <= i_label_req;
            if (i_label_req)
                o_accepted_payload_label <= i_rx_label;
        end
    end

    logic [N_ADAPT-1:0] act_q;

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            act_q <= '0;
        else if (SINGLE_CLIENT)
            act_q <= '1;
        else if (i_act_wr)
            act_q <= i_adapter_activate;
    end

    assign o_adapter_activate = act_q;

endmodule

// [tb/prot_chk.sv]
// Purpose: port assertions for protection provisioning
// Assumes: one clock, synchronous active-high reset
// Notes: ring commands unchecked, their set is still provisional
`timescale 1ns/100ps
module prot_chk
    import prot_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire scheme_t i_scheme,
    input wire logic i_cfg_wr,
    input wire prot_cfg_t i_cfg,
    input wire logic i_cmd_valid,
    input wire ext_cmd_t i_external_switch_command,
    input wire logic i_label_req,
    input wire logic [7:0] i_rx_label,
    input wire logic o_switch_select,
    input wire logic o_switch_event_report,
    input wire logic o_prot_operational,
    input wire ext_cmd_t o_active_command,
    input wire prot_cfg_t o_cfg,
    input wire logic o_label_ack,
    input wire logic [7:0] o_accepted_payload_label
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    function automatic bit legal(scheme_t s, ext_cmd_t c);
        return c != CMD_NONE && (c <= CMD_EXERCISE
            || (s == SCHEME_MSP && c <= CMD_CLEAR_LOCKOUT_NORMAL));
    endfunction
    function automatic ext_cmd_t held(ext_cmd_t c);
        return c inside {CMD_CLEAR, CMD_CLEAR_LOCKOUT_NORMAL} ? CMD_NONE : c;
    endfunction
    wire logic lin = i_cmd_valid && i_scheme != SCHEME_RING;
    wire logic ok = legal(i_scheme, i_external_switch_command);
////////////////////////////////////////////////////////////////////////////
    a_cmd_taken: assert property (
        lin && ok |=> o_active_command ==
        held($past(i_external_switch_command)))
        else $error("legal command not taken");
    a_cmd_refused: assert property (
        lin && !ok |=> $stable(o_active_command))
        else $error("illegal command changed state");
    a_event_pairs: assert property (
        !$past(I_SYS_RST) |->
        o_switch_event_report == $changed(o_switch_select))
        else $error("switch event not tied to select change");
    a_reset_state: assert property (
        $fell(I_SYS_RST) |-> !o_cfg.revert_select && !o_switch_select
        && o_cfg.restore_wait_minutes == 4'h5
        && o_cfg.holdoff_interval == 7'h00
        && o_active_command == CMD_NONE)
        else $error("wrong state after reset");
    a_wtr_limit: assert property (
        i_cfg_wr |=> o_cfg.restore_wait_minutes ==
        ($past(i_cfg.restore_wait_minutes) > 4'hC
        ? $past(o_cfg.restore_wait_minutes)
        : $past(i_cfg.restore_wait_minutes)))
        else $error("restore wait range not kept");
    a_lockout_wins: assert property (
        o_active_command == CMD_LOCKOUT || !o_prot_operational
        |=> !o_switch_select)
        else $error("protection selected under lockout");
    a_forced_on: assert property (
        o_active_command == CMD_FORCED && o_prot_operational
        |=> o_switch_select)
        else $error("forced switch not applied");
    a_oper_gate: assert property (
        o_prot_operational ==
        (i_scheme != SCHEME_SNC || o_cfg.monitor_type_set))
        else $error("operational flag wrong");
    a_label_reply: assert property (
        i_label_req |=> o_label_ack
        && o_accepted_payload_label == $past(i_rx_label))
        else $error("label reply wrong");
endmodule

bind prot_trace_prov prot_chk chk (
    .I_CLK, .I_SYS_RST, .i_scheme, .i_cfg_wr, .i_cfg, .i_cmd_valid,
    .i_external_switch_command, .i_label_req, .i_rx_label, .o_switch_select,
    .o_switch_event_report, .o_prot_operational, .o_active_command, .o_cfg,
    .o_label_ack, .o_accepted_payload_label
);

// [tb/mgr_model.sv]
// Purpose: manager side model issuing provisioning pulses
// Assumes: requests launched on the falling edge
// Notes: released data shows its inverse, never the last value
`timescale 1ns/100ps
module mgr_model
    import prot_pkg::*;
(
    input wire logic i_clk,
    output logic o_cfg_wr,
    output prot_cfg_t o_cfg,
    output logic o_cmd_valid,
    output ext_cmd_t o_cmd,
    output logic o_act_wr,
    output logic [1:0] o_act,
    output logic o_trace_req,
    output logic o_label_req
);
    logic [4:0] req = 5'h00;
    assign {o_label_req, o_trace_req, o_act_wr, o_cmd_valid, o_cfg_wr} = req;
    initial
    begin
        o_cfg = 16'h0000;
        o_cmd = CMD_NONE;
        o_act = 2'h0;
    end
    // kind 0 config, 1 command, 2 activation, 3 trace, 4 label
    task automatic send(input int k, input logic [15:0] v);
        @(negedge i_clk);
        o_cfg = v;
        o_cmd = ext_cmd_t'(v[3:0]);
        o_act = v[1:0];
        req = 5'(1 << k);
        @(negedge i_clk);
        req = 5'h00;
        o_cfg = ~v;
        o_cmd = ext_cmd_t'(~v[3:0]);
        o_act = ~v[1:0];
    endtask
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for protection provisioning
// Assumes: timers shortened through the counting parameters
// Notes: trace frames are exactly sixteen bytes, aligned from reset
`timescale 1ns/100ps
module tb_top
    import prot_pkg::*;
;
    logic I_CLK = 1'b0;
    logic I_SYS_RST = 1'b1;
    scheme_t i_scheme = SCHEME_SNC;
    logic pfail = 1'b0;
    logic twr = 1'b0;
    trace_cfg_t tcfg = 3'h0;
    logic [7:0] stv = 8'h00;
    logic [7:0] etv = 8'h00;
    logic oper, dfct;
    logic [7:0] txb, trv;
    logic [7:0] ex [16];
    logic [7:0] rxs [16];
    logic wfail = 1'b0;
    logic rx_v = 1'b0;
    logic [7:0] rx_b = 8'h00;
    logic [7:0] label = 8'h00;
    logic cfg_wr, cmd_v, act_wr, lreq, treq, sel, evt, tack, lack;
    prot_cfg_t cfg, ocfg, ecfg;
    ext_cmd_t cmd, acmd, ecmd;
    logic [1:0] act, oact;
    logic [7:0] lab;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int nevt = 0;
    int seed = 32'h618CF7BC;
    scheme_t sl [3] = '{SCHEME_MSP, SCHEME_SNC, SCHEME_TRAIL};
    mgr_model mgr (
        .i_clk(I_CLK), .o_cfg_wr(cfg_wr), .o_cfg(cfg), .o_cmd_valid(cmd_v),
        .o_cmd(cmd), .o_act_wr(act_wr), .o_act(act), .o_trace_req(treq),
        .o_label_req(lreq)
    );
    prot_trace_prov #(.SEC_CYCLES(32'h4), .STEP_CYCLES(32'h2)) dut (
        .I_CLK, .I_SYS_RST, .i_scheme, .i_cfg_wr(cfg_wr), .i_cfg(cfg),
        .i_cmd_valid(cmd_v), .i_external_switch_command(cmd),
        .i_working_fail(wfail), .i_protect_fail(pfail), .i_trace_wr(twr),
        .i_trace_cfg(tcfg), .i_sent_trace_value(stv),
        .i_expected_trace_value(etv), .i_rx_trace_valid(rx_v),
        .i_rx_trace_byte(rx_b), .i_trace_req(treq), .i_label_req(lreq),
        .i_rx_label(label), .i_act_wr(act_wr), .i_adapter_activate(act),
        .o_tx_trace_byte(txb), .o_switch_select(sel),
        .o_switch_event_report(evt),
        .o_prot_operational(oper), .o_active_command(acmd), .o_cfg(ocfg),
        .o_trace_mismatch_defect(dfct), .o_trace_ack(tack),
        .o_accepted_trace_value(trv), .o_label_ack(lack),
        .o_accepted_payload_label(lab), .o_adapter_activate(oact)
    );
    always #12.5 I_CLK = ~I_CLK;
    // sampled on the falling edge, clear of the register updates
    always @(negedge I_CLK)
    begin
        cyc++;
        nevt += int'(evt === 1'b1);
        if (cyc == 5000)
        begin
            err_count++;
            end_of_test();
        end
    end
////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time,
                got, exp);
        end
    endtask
    task automatic wait_sel(input logic v);
        int n;
        n = 0;
        while (sel !== v && n < 40)
        begin
            @(negedge I_CLK);
            n++;
        end
        chk({15'h0000, sel}, {15'h0000, v});
    endtask
    function automatic prot_cfg_t next_cfg(prot_cfg_t q, prot_cfg_t c);
        next_cfg = c;
        if (c.restore_wait_minutes > 4'hC)
            next_cfg.restore_wait_minutes = q.restore_wait_minutes;
        if (c.holdoff_interval > 7'h64)
            next_cfg.holdoff_interval = q.holdoff_interval;
    endfunction
    function automatic ext_cmd_t next_cmd(scheme_t s, ext_cmd_t q, ext_cmd_t c);
        if (c == CMD_NONE || c > (s == SCHEME_MSP ? CMD_CLEAR_LOCKOUT_NORMAL
            : CMD_EXERCISE))
            return q;
        return (c == CMD_CLEAR || c == CMD_CLEAR_LOCKOUT_NORMAL) ? CMD_NONE : c;
    endfunction
    // one trace write; the design's write index follows idx
    task automatic twrite(input int idx, input trace_cfg_t t);
        @(negedge I_CLK);
        twr = 1'b1;
        tcfg = t;
        stv = 8'(idx);
        etv = ex[idx];
        @(negedge I_CLK);
        twr = 1'b0;
    endtask
    task automatic frame(input bit one, input bit bad);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge I_CLK);
            rx_v = 1'b1;
            rx_b = (one ? ex[0] : ex[i]) ^ {7'h00, bad && i == 5};
            rxs[i] = rx_b;
        end
        @(negedge I_CLK);
        rx_v = 1'b0;
        @(negedge I_CLK);
        chk({15'h0000, dfct}, {15'h0000, bad});
    endtask
    task automatic end_of_test;
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////
    initial
    begin
        prot_cfg_t c;
        logic [15:0] v;
        repeat (10) @(posedge I_CLK);
        @(negedge I_CLK);
        I_SYS_RST = 1'b0;
        chk({ocfg[15], ocfg[10:0], acmd},
            {5'h05, 7'h00, CMD_NONE});
        chk({sel, oact, oper, 12'h000}, 16'h0000);
        ecfg = 16'h0280;
        for (int i = 0; i < 24; i++)
        begin
            c = 16'($random(seed));
            c.monitor_type_set = 1'b1;
            // walk both range limits first
            if (i < 4)
                c[10:0] = {4'(12 + i), 7'(99 + i)};
            mgr.send(0, c);
            ecfg = next_cfg(ecfg, c);
            chk(ocfg, ecfg);
        end
        c = 16'h0000;
        c.revert_select = 1'b1;
        c.monitor_type_set = 1'b1;
        mgr.send(0, c);
        chk({15'h0000, oper}, 16'h0001);
        for (int i = 0; i < 16; i++)
            ex[i] = 8'($random(seed));
        for (int i = 0; i < 16; i++)
            twrite(i, 3'h0);
        @(negedge I_CLK);
        v = 16'(txb);
        @(negedge I_CLK);
        chk({8'h00, txb}, {12'h000, 4'(v[3:0] + 4'h1)});
        frame(1'b0, 1'b0);
        twrite(0, 3'h2);
        frame(1'b1, 1'b0);
        twrite(1, 3'h0);
        frame(1'b0, 1'b1);
        twrite(2, 3'h1);
        @(negedge I_CLK);
        chk({15'h0000, dfct}, 16'h0000);
        for (int n = 0; n < 4; n++)
        begin
            label = 8'($random(seed));
            mgr.send(4, 16'h0000);
            chk({7'h00, lack, lab}, {8'h01, label});
            v = 16'($random(seed));
            mgr.send(2, v);
            chk({14'h0000, oact}, {14'h0000, v[1:0]});
            mgr.send(3, 16'h0000);
            chk({7'h00, tack, trv}, {8'h01, rxs[n]});
        end
        ecmd = CMD_NONE;
        foreach (sl[j])
        begin
            i_scheme = sl[j];
            for (int k = 0; k < 20; k++)
            begin
                v = k < 16 ? 16'(k) : 16'($random(seed));
                mgr.send(1, v);
                ecmd = next_cmd(i_scheme, ecmd, ext_cmd_t'(v[3:0]));
                chk({12'h000, acmd}, {12'h000, ecmd});
            end
        end
        i_scheme = SCHEME_SNC;
        mgr.send(1, 16'(CMD_CLEAR));
        wait_sel(1'b0);
        // restart the count off the negedge counter's time step
        @(posedge I_CLK);
        nevt = 0;
        mgr.send(1, 16'(CMD_FORCED));
        wait_sel(1'b1);
        mgr.send(1, 16'(CMD_LOCKOUT));
        wait_sel(1'b0);
        mgr.send(1, 16'(CMD_CLEAR));
        mgr.send(1, 16'(CMD_MANUAL));
        wait_sel(1'b1);
        mgr.send(1, 16'(CMD_CLEAR));
        wait_sel(1'b0);
        wfail = 1'b1;
        wait_sel(1'b1);
        wfail = 1'b0;
        wait_sel(1'b0);
        repeat (2) @(negedge I_CLK);
        chk(16'(nevt), 16'h0006);
        pfail = 1'b1;
        wfail = 1'b1;
        mgr.send(1, 16'(CMD_MANUAL));
        repeat (3) @(negedge I_CLK);
        chk({15'h0000, sel}, 16'h0000);
        pfail = 1'b0;
        wait_sel(1'b1);
        wfail = 1'b0;
        mgr.send(1, 16'(CMD_CLEAR));
        wait_sel(1'b0);
        end_of_test();
    end
endmodule
